// ### hw/ssl_map.svh
`ifndef SSL_MAP_SVH
`define SSL_MAP_SVH

// Local clock
`define SSL_CLK_PERIOD_NS 8

// Serial byte framing
`define SSL_BYTE_BITS 8
`define SSL_BIT_CNT_W 3
`define SSL_LAST_BIT 3'h7
`define SSL_RX_WORD_W 9
`define SSL_RX_FIRST_BIT 8
`define SSL_IDLE_BYTE 8'hFF

// Receive buffer depth
`define SSL_BUF_DEPTH 2

// Self-timed write durations (typical) and the ceilings they must respect
`define SSL_PAGE_WRITE_MS 1
`define SSL_PAGE_WRITE_MAX_MS 5
`define SSL_PAGE_WRITE_CYC ((`SSL_PAGE_WRITE_MS * 1000000) / `SSL_CLK_PERIOD_NS)
`define SSL_PAGE_WRITE_MAX_CYC \
  ((`SSL_PAGE_WRITE_MAX_MS * 1000000) / `SSL_CLK_PERIOD_NS)
`define SSL_BYTE_WRITE_US 25
`define SSL_BYTE_WRITE_MAX_US 100
`define SSL_BYTE_WRITE_CYC ((`SSL_BYTE_WRITE_US * 1000) / `SSL_CLK_PERIOD_NS)
`define SSL_BUSY_W 17

// Deselect to standby, longest time, less the pin-to-state latency
`define SSL_IDLE_MAX_US 8
`define SSL_DESEL_LAT 4
`define SSL_IDLE_CYC \
  (((`SSL_IDLE_MAX_US * 1000) / `SSL_CLK_PERIOD_NS) - `SSL_DESEL_LAT)
`define SSL_IDLE_W 10

// Synchroniser reset levels: select and pause idle high, clock low
`define SSL_SYNC_W 4
`define SSL_SYNC_RESET 4'h9

`endif

// ### hw/ssl_pkg.sv
`include "ssl_map.svh"

package ssl_pkg;

  typedef logic [`SSL_BYTE_BITS-1:0] ssl_byte_t;
  typedef logic [`SSL_RX_WORD_W-1:0] ssl_rxword_t;

  typedef enum logic [1:0] {
    LINK_IDLE,
    LINK_SHIFT,
    LINK_HOLD
  } ssl_link_e;

  typedef struct packed {
    ssl_link_e link;
    logic sckPrev;
    logic [`SSL_BIT_CNT_W-1:0] bitCnt;
    ssl_byte_t rxShift;
    ssl_byte_t txShift;
    logic txArmed;
    logic firstByte;
    logic overrun;
    logic standby;
    logic [`SSL_IDLE_W-1:0] idleCnt;
    logic busy;
    logic pageKind;
    logic [`SSL_BUSY_W-1:0] busyCnt;
  } ssl_link_s;

endpackage

// ### hw/ssl_sync.sv
`timescale 1ns/1ps
`default_nettype none

module ssl_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  import ssl_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } ssl_sync_s;

  ssl_sync_s st_ff;
  ssl_sync_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.stage1 = asyncIn;
    nxt_st.stage2 = st_ff.stage1;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= {RESET_VAL, RESET_VAL};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign syncOut = st_ff.stage2;

endmodule // ssl_sync

`default_nettype wire

// ### hw/ssl_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module ssl_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Fill side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Drain side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  import ssl_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [CW-1:0] count;
  } ssl_fifo_s;

  ssl_fifo_s st_ff;
  ssl_fifo_s nxt_st;
  logic doPush;
  logic doPop;

  assign inReady = (st_ff.count != FULL);
  assign outValid = (st_ff.count != '0);
  assign outData = st_ff.mem[st_ff.rdPtr];
  assign doPush = inValid & inReady;
  assign doPop = outValid & outReady;

  always_comb begin
    nxt_st = st_ff;
    if (doPush) begin
      nxt_st.mem[st_ff.wrPtr] = inData;
      nxt_st.wrPtr = (st_ff.wrPtr == LAST) ? '0 : st_ff.wrPtr + 1'b1;
    end
    if (doPop) begin
      nxt_st.rdPtr = (st_ff.rdPtr == LAST) ? '0 : st_ff.rdPtr + 1'b1;
    end
    if (doPush && !doPop) begin
      nxt_st.count = st_ff.count + 1'b1;
    end else if (doPop && !doPush) begin
      nxt_st.count = st_ff.count - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule // ssl_fifo

`default_nettype wire

// ### hw/ssl_link.sv
// Overview of operation
// - Select low activates the serial logic
// - Select high deselects, heads to standby
// - Deselected: ignore input, output high impedance
// - Sample input bits on rising serial clock
// - Launch output bits on falling serial clock
// - Pause low freezes sequence, resumes intact
// - Page write self-timed, within page duration
// - Byte write self-timed, within byte duration
// - Standby reached within limit after deselect
// - Bytes shifted most significant bit first
`timescale 1ns/1ps
`default_nettype none
`include "ssl_map.svh"

module ssl_link #(
  parameter int PAGE_WRITE_CYCLES = `SSL_PAGE_WRITE_CYC,
  parameter int BUF_DEPTH = `SSL_BUF_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Serial pins
  input wire logic selectN,
  input wire logic sckPin,
  input wire logic serial_in_line,
  input wire logic pauseN,
  output logic serial_out_line,
  output logic serialOutEn,
  // Received bytes toward the command logic
  output logic rxValid,
  output ssl_pkg::ssl_byte_t rxData,
  output logic rxFirst,
  input wire logic rxReady,
  // Bytes to send
  input wire logic txValid,
  input wire ssl_pkg::ssl_byte_t txData,
  output logic txReady,
  // Self-timed write control
  input wire logic writeStart,
  input wire logic writeIsPage,
  output logic writeBusy,
  // Link status
  output logic linkSelected,
  output logic linkStandby,
  output logic rxOverrun
);
  import ssl_pkg::*;

  localparam logic [`SSL_BUSY_W-1:0] PAGE_CYC =
    `SSL_BUSY_W'(PAGE_WRITE_CYCLES);
  localparam logic [`SSL_BUSY_W-1:0] BYTE_CYC =
    `SSL_BUSY_W'(`SSL_BYTE_WRITE_CYC);
  localparam logic [`SSL_IDLE_W-1:0] IDLE_CYC =
    `SSL_IDLE_W'(`SSL_IDLE_CYC);

  ssl_link_s st_ff;
  ssl_link_s nxt_st;
  logic [`SSL_SYNC_W-1:0] pinSync;
  logic csS;
  logic sckS;
  logic dinS;
  logic pauseS;
  logic sckRise;
  logic sckFall;
  logic pushValid;
  logic pushReady;
  ssl_rxword_t pushData;
  ssl_rxword_t popData;

  // Every pin crosses two flip-flops before use
  ssl_sync #(
    .WIDTH(`SSL_SYNC_W),
    .RESET_VAL(`SSL_SYNC_RESET)
  ) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .asyncIn({selectN, sckPin, serial_in_line, pauseN}),
    .syncOut(pinSync)
  );

  assign csS = pinSync[3];
  assign sckS = pinSync[2];
  assign dinS = pinSync[1];
  assign pauseS = pinSync[0];

  assign sckRise = sckS & ~st_ff.sckPrev;
  assign sckFall = ~sckS & st_ff.sckPrev;

  // Completed byte: MSB arrived first, last bit taken from the synchronised input, not the shift register
  assign pushData = {st_ff.firstByte, st_ff.rxShift[6:0], dinS};

  always_comb begin
    nxt_st = st_ff;
    pushValid = 1'b0;
    txReady = 1'b0;
    nxt_st.sckPrev = sckS;
    case (st_ff.link)
      LINK_IDLE: begin
        if (!csS) begin
          nxt_st.link = LINK_SHIFT;
          nxt_st.bitCnt = '0;
          nxt_st.txArmed = 1'b0;
          nxt_st.firstByte = 1'b1;
          nxt_st.overrun = 1'b0;
          nxt_st.standby = 1'b0;
          nxt_st.idleCnt = '0;
        end else if (!st_ff.standby) begin
          if (st_ff.idleCnt >= IDLE_CYC - 1'b1) begin
            nxt_st.standby = 1'b1;
          end else begin
            nxt_st.idleCnt = st_ff.idleCnt + 1'b1;
          end
        end
      end
      LINK_SHIFT: begin
        if (csS) begin
          nxt_st.link = LINK_IDLE;
          nxt_st.txArmed = 1'b0;
          nxt_st.idleCnt = '0;
        end else if (!pauseS) begin
          nxt_st.link = LINK_HOLD;
        end else begin
          if (sckRise) begin
            nxt_st.rxShift = {st_ff.rxShift[6:0], dinS};
            nxt_st.bitCnt = st_ff.bitCnt + 1'b1;
            if (st_ff.bitCnt == `SSL_LAST_BIT) begin
              pushValid = 1'b1;
              nxt_st.firstByte = 1'b0;
              if (!pushReady) begin
                nxt_st.overrun = 1'b1;
              end
            end
          end
          if (sckFall) begin
            if (st_ff.bitCnt == '0) begin
              txReady = 1'b1;
              nxt_st.txShift = txValid ? txData : `SSL_IDLE_BYTE;
              nxt_st.txArmed = st_ff.txArmed | txValid;
            end else begin
              nxt_st.txShift = {st_ff.txShift[6:0], 1'b0};
            end
          end
        end
      end
      LINK_HOLD: begin
        if (csS) begin
          nxt_st.link = LINK_IDLE;
          nxt_st.txArmed = 1'b0;
          nxt_st.idleCnt = '0;
        end else if (pauseS) begin
          nxt_st.link = LINK_SHIFT;
        end
      end
      default: begin
        nxt_st.link = LINK_IDLE;
      end
    endcase
    // Self-timed write; a start while busy is ignored
    if (st_ff.busy) begin
      if (st_ff.busyCnt == '0) begin
        nxt_st.busy = 1'b0;
      end else begin
        nxt_st.busyCnt = st_ff.busyCnt - 1'b1;
      end
    end else if (writeStart) begin
      nxt_st.busy = 1'b1;
      nxt_st.pageKind = writeIsPage;
      nxt_st.busyCnt = writeIsPage ? PAGE_CYC - 1'b1
                                   : BYTE_CYC - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{link: LINK_IDLE, sckPrev: 1'b0, bitCnt: '0, rxShift: '0,
                 txShift: '0, txArmed: 1'b0, firstByte: 1'b0,
                 overrun: 1'b0, standby: 1'b1, idleCnt: '0, busy: 1'b0,
                 pageKind: 1'b0, busyCnt: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Two-entry buffer absorbs a stall by the byte consumer
  ssl_fifo #(
    .WIDTH(`SSL_RX_WORD_W),
    .DEPTH(BUF_DEPTH)
  ) u_rxbuf (
    .clock(clock),
    .rst_n(rst_n),
    .inValid(pushValid),
    .inData(pushData),
    .inReady(pushReady),
    .outValid(rxValid),
    .outData(popData),
    .outReady(rxReady)
  );

  assign rxData = popData[`SSL_BYTE_BITS-1:0];
  assign rxFirst = popData[`SSL_RX_FIRST_BIT];
  assign serial_out_line = st_ff.txShift[7];
  // Output only while selected and not paused, once a reply byte has been loaded in this frame
  assign serialOutEn = (st_ff.link == LINK_SHIFT) & st_ff.txArmed;
  assign writeBusy = st_ff.busy;
  assign linkSelected = (st_ff.link != LINK_IDLE);
  assign linkStandby = st_ff.standby;
  assign rxOverrun = st_ff.overrun;

  // Helper counters read only by the checks below
  logic [`SSL_IDLE_W:0] deselWait;
  logic [`SSL_BUSY_W:0] busyLen;
  logic [`SSL_BIT_CNT_W-1:0] riseCnt;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      deselWait <= '0;
      busyLen <= '0;
      riseCnt <= '0;
    end else begin
      deselWait <= (st_ff.link == LINK_IDLE && !st_ff.standby)
                   ? deselWait + 1'b1 : '0;
      busyLen <= st_ff.busy ? busyLen + 1'b1 : '0;
      if (st_ff.link == LINK_IDLE) begin
        riseCnt <= '0;
      end else if (st_ff.link == LINK_SHIFT && !csS && pauseS && sckRise) begin
        riseCnt <= riseCnt + 1'b1;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence selEdge;
    st_ff.link == LINK_IDLE && !csS;
  endsequence

  sequence shiftRise;
    st_ff.link == LINK_SHIFT && !csS && pauseS && sckRise;
  endsequence

  sequence shiftFall;
    st_ff.link == LINK_SHIFT && !csS && pauseS && sckFall
      && st_ff.bitCnt != '0;
  endsequence

  select_start_a: assert property (selEdge |=> linkSelected ##0 !linkStandby)
    else $error("select did not start a frame");

  deselect_stop_a: assert property (
    linkSelected && csS |=> !linkSelected ##1 !linkSelected)
    else $error("deselect did not end the frame");

  desel_hiz_a: assert property (!linkSelected |-> !serialOutEn)
    else $error("output driven while deselected");

  rx_sample_a: assert property (
    shiftRise |=> st_ff.rxShift[0] == $past(dinS))
    else $error("input bit not sampled on rising edge");

  tx_launch_a: assert property (
    shiftFall |=> serial_out_line == $past(st_ff.txShift[6]))
    else $error("output bit not launched on falling edge");

  hold_freeze_a: assert property (
  // The resume cycle is left out: the loaded reply may drive again there
  // Standby counter budget already allows for the select synchroniser
    st_ff.link == LINK_HOLD && !csS && !pauseS |=>
      $stable(st_ff.rxShift) && $stable(st_ff.bitCnt) && !serialOutEn)
    else $error("pause did not freeze the sequence");

  page_time_a: assert property (
    $fell(st_ff.busy) && st_ff.pageKind |-> busyLen == PAGE_CYC
      && PAGE_WRITE_CYCLES <= `SSL_PAGE_WRITE_MAX_CYC)
    else $error("page write time wrong");

  byte_time_a: assert property (
    $fell(st_ff.busy) && !st_ff.pageKind |-> busyLen == BYTE_CYC
      && BYTE_CYC <= `SSL_BUSY_W'((`SSL_BYTE_WRITE_MAX_US * 1000)
                                  / `SSL_CLK_PERIOD_NS))
    else $error("byte write time wrong");

  standby_bound_a: assert property (
    deselWait <= {1'b0, IDLE_CYC})
    else $error("standby not reached in time");

  msb_first_a: assert property (
    pushValid |-> riseCnt == `SSL_LAST_BIT
      && pushData[7:1] == st_ff.rxShift[6:0])
    else $error("byte boundary or bit order wrong");

endmodule // ssl_link

`default_nettype wire

// ### tb/ssl_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module ssl_master_model (
  // Serial pins toward the device
  output logic selectN,
  output logic sckPin,
  output logic serial_in_line,
  output logic pauseN,
  input wire logic serial_out_line,
  input wire logic serialOutEn
);
  logic [7:0] got;

  initial begin
    selectN = 1'b1;
    sckPin = 1'b0; // Mode 0: clock idles low
    serial_in_line = 1'b0;
    pauseN = 1'b1;
    got = 8'h00;
  end

  task automatic open_frame();
    selectN = 1'b0;
    #125;
  endtask

  // Clock period 125 ns, fast read traffic
  // No normal or auto sleep frames are sent at this rate
  task automatic shift(input logic [7:0] d, input int n);
    for (int i = 0; i < n; i++) begin
      serial_in_line = d[7-i]; // Most significant bit first
      #62.5;
      sckPin = 1'b1;
      got = {got[6:0], serialOutEn ? serial_out_line : 1'bz};
      #62.5;
      sckPin = 1'b0;
    end
  endtask

  task automatic close_frame();
    #62.5;
    selectN = 1'b1;
    // A released line must not keep showing its last bit
    serial_in_line = ~serial_in_line;
  endtask

  task automatic set_pause(input logic v);
    pauseN = v;
  endtask

  // Pulses that the device must not count; run low keeps the clock idle
  task automatic idle_pulses(input int n, input logic run);
    for (int i = 0; i < n; i++) begin
      serial_in_line = ~serial_in_line;
      #62.5;
      sckPin = run;
      #62.5;
      sckPin = 1'b0;
    end
  endtask

  // Wake sequences: a short select pulse, or a wake byte, then the wait
  task automatic wake(input logic deep, input logic [7:0] d);
    if (deep) begin
      selectN = 1'b0;
      #25; // At least the deep sleep wake pulse
      selectN = 1'b1;
      #70000; // Deep sleep exit wait
    end else begin
      open_frame();
      shift(d, 8);
      close_frame();
      #50000; // Sleep exit wait before the next operation
    end
  endtask
endmodule // ssl_master_model

`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import ssl_pkg::*;
  logic clock, rst_n, selectN, sckPin, serial_in_line, pauseN;
  logic serial_out_line, serialOutEn, rxValid, rxFirst, rxReady;
  logic txValid, txReady, writeStart, writeIsPage, writeBusy;
  logic linkSelected, linkStandby, rxOverrun;
  ssl_byte_t rxData, txData;
  int n_fail, samples_checked;
  int txPulses;

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Byte boundaries seen by the reply path
  always @(posedge clock) begin
    if (!rst_n) begin
      txPulses <= 0;
    end else if (txReady === 1'b1) begin
      txPulses <= txPulses + 1;
    end
  end

  ssl_link #(.PAGE_WRITE_CYCLES(200)) ssl_link_i (
    .clock(clock), .rst_n(rst_n), .selectN(selectN), .sckPin(sckPin),
    .serial_in_line(serial_in_line), .pauseN(pauseN),
    .serial_out_line(serial_out_line), .serialOutEn(serialOutEn),
    .rxValid(rxValid), .rxData(rxData), .rxFirst(rxFirst),
    .rxReady(rxReady), .txValid(txValid), .txData(txData),
    .txReady(txReady), .writeStart(writeStart),
    .writeIsPage(writeIsPage), .writeBusy(writeBusy),
    .linkSelected(linkSelected), .linkStandby(linkStandby),
    .rxOverrun(rxOverrun));

  ssl_master_model ssl_master_model_i (
    .selectN(selectN), .sckPin(sckPin), .serial_in_line(serial_in_line),
    .pauseN(pauseN), .serial_out_line(serial_out_line),
    .serialOutEn(serialOutEn));

  task automatic check(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic pop(input ssl_byte_t b, input logic f);
    check("rxValid", rxValid, 1'b1);
    check("rxData", rxData, b);
    check("rxFirst", rxFirst, f);
    rxReady = 1'b1;
    @(negedge clock);
    rxReady = 1'b0;
    @(negedge clock);
  endtask

  task automatic test_reset();
    check("serialOutEn", serialOutEn, 1'b0);
    check("linkStandby", linkStandby, 1'b1);
    check("linkSelected", linkSelected, 1'b0);
    check("writeBusy", writeBusy, 1'b0);
    $display("test reset done");
  endtask

  task automatic test_frame();
    int n;
    int t0;
    t0 = txPulses;
    txValid = 1'b1;
    txData = 8'h96;
    ssl_master_model_i.open_frame();
    check("linkSelected", linkSelected, 1'b1);
    check("linkStandby", linkStandby, 1'b0);
    ssl_master_model_i.shift(8'hA5, 8);
    ssl_master_model_i.shift(8'h3C, 8);
    check("reply", ssl_master_model_i.got, 8'h96);
    ssl_master_model_i.shift(8'h5A, 8);
    ssl_master_model_i.close_frame();
    n = 0;
    while (linkSelected !== 1'b0 && n < 20) begin
      @(negedge clock);
      n++;
    end
    txValid = 1'b0;
    check("serialOutEn", serialOutEn, 1'b0);
    check("deselect", linkSelected, 1'b0);
    check("txReady", txPulses - t0, 3);
    while (linkStandby !== 1'b1 && n < 1100) begin
      @(negedge clock);
      n++;
    end
    check("standbyTime", n >= 990 && n <= 1010, 1'b1);
    check("rxOverrun", rxOverrun, 1'b1);
    pop(8'hA5, 1'b1);
    pop(8'h3C, 1'b0);
    check("empty", rxValid, 1'b0);
    $display("test frame done");
  endtask

  task automatic test_ignore();
    ssl_master_model_i.idle_pulses(16, 1'b0);
    repeat (10) @(negedge clock);
    check("ignored", rxValid, 1'b0);
    check("ignoredSel", linkSelected, 1'b0);
    check("serialOutEn", serialOutEn, 1'b0);
    $display("test ignore done");
  endtask

  task automatic test_pause();
    ssl_master_model_i.open_frame();
    ssl_master_model_i.shift(8'hC3, 4);
    ssl_master_model_i.set_pause(1'b0);
    #100;
    ssl_master_model_i.idle_pulses(4, 1'b1);
    check("pausedSel", linkSelected, 1'b1);
    ssl_master_model_i.set_pause(1'b1);
    #100;
    ssl_master_model_i.shift(8'h30, 4);
    ssl_master_model_i.close_frame();
    repeat (8) @(negedge clock);
    check("rxOverrun", rxOverrun, 1'b0);
    pop(8'hC3, 1'b1);
    check("single", rxValid, 1'b0);
    $display("test pause done");
  endtask

  task automatic test_wake();
    ssl_master_model_i.wake(1'b1, 8'h00);
    @(negedge clock);
    check("wakeSel", linkSelected, 1'b0);
    check("wakeEmpty", rxValid, 1'b0);
    check("wakeStandby", linkStandby, 1'b1);
    ssl_master_model_i.wake(1'b0, 8'h5E);
    @(negedge clock);
    pop(8'h5E, 1'b1);
    check("wakeOnly", rxValid, 1'b0);
    $display("test wake done");
  endtask

  task automatic test_write(input logic page, input int expN);
    int n;
    writeIsPage = page;
    writeStart = 1'b1;
    @(negedge clock);
    writeStart = 1'b0;
    n = 0;
    // A restart during the write must be ignored
    while (writeBusy === 1'b1 && n < 5000) begin
      writeStart = (n == 10);
      @(negedge clock);
      n++;
    end
    check("busyCycles", n, expN);
    $display("test write done");
  endtask

  initial begin
    n_fail = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    rxReady = 1'b0;
    txValid = 1'b0;
    txData = 8'h00;
    writeStart = 1'b0;
    writeIsPage = 1'b0;
    repeat (4) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    repeat (2) @(negedge clock);
    test_reset();
    test_frame();
    test_ignore();
    test_pause();
    test_wake();
    test_write(1'b1, 200);
    test_write(1'b0, 3125);
    results();
  end
endmodule // tb_top

`default_nettype wire
